// File: bench/fcm_frame_ctrl_monitor.sv
// Checker of the frame control bank, bound onto its ports.
// Assumes one clock, ref_clk, and synchronous reset sys_rst.
`timescale 1ns/100ps
module fcm_frame_ctrl_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic [23:0] shortMatchEn,
    input wire logic [11:0] long_entry_match_enables,
    // Stream flags
    input wire logic symbolSearchEn,
    input wire logic txFifoEmpty,
    input wire logic txByteReq,
    input wire logic txByteValid,
    input wire logic txActive,
    input wire logic txDone,
    input wire logic txUnderflow,
    input wire logic ackSent
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // A control write followed by a quiet cycle.
    sequence s_ctrl_wr;
        regWrite && regAddr == 8'h0c ##1 !regWrite;
    endsequence
    // Every read is answered exactly one cycle later.
    chk_read_answer: assert property (regRead |=> regRdValid)
        else $error("read strobe not answered");
    chk_ext_pairs: assert property (regRead && regAddr inside {8'h08, 8'h09, 8'h0a} |=>
        (regRdData & 8'h55) == ((regRdData >> 1) & 8'h55)) else $error("pair bits differ");
    chk_short_high: assert property (regWrite && regAddr == 8'h06 |=>
        shortMatchEn[23:16] == $past(regWrData)) else $error("short enable not stored");
    chk_ext_even: assert property (regWrite && regAddr == 8'h08 |=> ##1
        long_entry_match_enables[3:0] == {$past(regWrData[6], 2), $past(regWrData[4], 2),
        $past(regWrData[2], 2), $past(regWrData[0], 2)}) else $error("ext low wrong");
    chk_ext_top: assert property (regWrite && regAddr == 8'h0a |=> ##1
        long_entry_match_enables[8] == $past(regWrData[0], 2)) else $error("ext top wrong");
    // Symbol search follows the receive mode field.
    chk_no_search: assert property (s_ctrl_wr |=>
        symbolSearchEn == ($past(regWrData[3:2], 2) != 2'h3)) else $error("search level");
    chk_tx_answer: assert property (txByteValid |-> $past(txByteReq))
        else $error("byte without request");
    chk_underflow_abort: assert property (txUnderflow |-> $past(txFifoEmpty) ##[0:1]
        !txActive) else $error("underflow not aborting");
    chk_ack_last: assert property (ackSent |-> txDone && txByteValid)
        else $error("ack end mismatch");
endmodule // fcm_frame_ctrl_monitor
bind fcm_frame_ctrl fcm_frame_ctrl_monitor fcm_frame_ctrl_monitor_inst (.*);

// File: bench/fcm_mod_model.sv
// Modulator stand-in: paces byte requests and records the bytes given.
// Assumes the bank's transmit port on ref_clk; drives on the falling edge.
`timescale 1ns/100ps
module fcm_mod_model (
    // Clock
    input wire logic ref_clk,
    // Byte stream from the bank
    input wire logic txByteValid,
    input wire logic [7:0] txByte,
    output logic txByteReq
);
    logic [1:0] pace = 2'h0;
    logic [7:0] got[$];
    initial txByteReq = 1'b0;
    // A request every fourth cycle, as a slow modulator would ask.
    always @(negedge ref_clk) begin
        pace <= pace + 2'h1;
        txByteReq <= (pace == 2'h3);
    end
    // Record every byte handed over.
    always @(posedge ref_clk) begin
        if (txByteValid === 1'b1) got.push_back(txByte);
    end
endmodule // fcm_mod_model

// File: bench/tb_top.sv
// Self-checking bench of the frame control bank.
// Assumes the package, the design and the modulator stand-in compile first.
`timescale 1ns/100ps
module tb_top;
    import fcm_pkg::*;
    // ----
    // Signals
    // ----
    logic ref_clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, regRdValid;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rxByte = 8'h00, rxFifoData;
    logic [23:0] shortMatchEn;
    logic [11:0] long_entry_match_enables;
    logic rxByteValid = 1'b0, rxByteLast = 1'b0, rxFifoFull = 1'b0, rxFifoWrite, rxOverflow;
    logic rssiValid = 1'b0, txFifoEmpty = 1'b0, txStart = 1'b0, txStop = 1'b0, txFifoRead;
    logic symbolSearchEn, txByteReq, txByteValid, txActive, txDone, txUnderflow, ackSent;
    logic signed [7:0] rssiIn = 8'sh00, rssiValue;
    logic [7:0] transmit_buffer_port = 8'h41, txByte;
    logic [6:0] txLen = 7'h03;
    fcm_rx_info_t rxInfo = '0;
    logic [7:0] fifoGot[$], pay[$], want[$];
    logic [7:0] offs[7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};
    logic [7:0] ctl[3] = '{8'h40, 8'hc0, 8'h00};
    logic [1:0] modes[3] = '{2'h0, 2'h2, 2'h3};
    int bad_count = 0, cmp_count = 0, cycles = 0, pops = 0;
    fcm_frame_ctrl #(.ACK_DELAY_CYCLES(20)) fcm_frame_ctrl_inst (.*);
    fcm_mod_model fcm_mod_model_inst (.*);
    initial forever #10 ref_clk = ~ref_clk;
    // Cycle ceiling and capture of receive FIFO writes.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (rxFifoWrite === 1'b1) fifoGot.push_back(rxFifoData);
        if (txFifoRead === 1'b1) pops++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmpq(input string what, input logic [7:0] e[$], input logic [7:0] g[$]);
        chk(what, 16'(e.size()), 16'(g.size()));
        foreach (e[i]) chk(what, 16'(e[i]), 16'(g[i]));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regWrite = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge ref_clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge ref_clk);
        regRead = 1'b0;
        chk("regRdValid", 16'h1, 16'(regRdValid));
        chk("regRdData", 16'(exp), 16'(regRdData));
    endtask
    task automatic rssi(input logic [7:0] v);
        @(negedge ref_clk);
        rssiValid = 1'b1;
        rssiIn = v;
        @(negedge ref_clk);
        rssiValid = 1'b0;
    endtask
    task automatic rxf(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(negedge ref_clk);
            rxByteValid = 1'b1;
            rxByte = q[i];
            rxByteLast = (i == q.size() - 1);
        end
        @(negedge ref_clk);
        rxByteValid = 1'b0;
        rxByteLast = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic waitTx();
        for (int n = 0; n < 300 && txDone !== 1'b1 && txUnderflow !== 1'b1; n++) @(negedge ref_clk);
    endtask
    task automatic txGo();
        fcm_mod_model_inst.got.delete();
        @(negedge ref_clk);
        txStart = 1'b1;
        @(negedge ref_clk);
        txStart = 1'b0;
        waitTx();
    endtask
    function automatic void crcq(inout logic [7:0] q[$]);
        logic [15:0] r;
        r = 16'h0000;
        foreach (q[i]) for (int b = 0; b < 8; b++) r = (r[0] ^ q[i][b]) ? (r >> 1) ^ 16'h8408 : r >> 1;
        q.push_back(r[7:0]);
        q.push_back(r[15:8]);
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----
    // Test sequence
    // ----
    initial begin
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        rd(8'h0c, 8'h40);
        foreach (offs[i]) rd(offs[i], 8'h00);
        $display("reset values done");
        wr(8'h06, 8'ha5);
        rd(8'h06, 8'ha5);
        chk("shortMatchEn", 16'ha500, shortMatchEn[23:8]);
        wr(8'h08, 8'haa);
        rd(8'h08, 8'h00);
        wr(8'h08, 8'h05);
        rd(8'h08, 8'h0f);
        wr(8'h09, 8'h40);
        rd(8'h09, 8'hc0);
        wr(8'h0a, 8'h11);
        rd(8'h0a, 8'h33);
        chk("long enables", 16'h0583, 16'(long_entry_match_enables));
        $display("match enables done");
        foreach (modes[i]) begin
            wr(8'h0c, {4'h4, modes[i], modes[i]});
            rd(8'h0c, {4'h4, modes[i], modes[i]});
            chk("symbolSearchEn", 16'(modes[i] != 2'h3), 16'(symbolSearchEn));
        end
        $display("modes done");
        pay = '{8'h41};
        crcq(pay);
        rxInfo.correlation = 7'h35;
        rxInfo.source_match_result_index = 7'h2c;
        foreach (ctl[i]) begin
            wr(8'h0c, ctl[i]);
            rssi(8'h1e);
            fifoGot.delete();
            rxf(pay);
            want = pay;
            if (ctl[i][6]) want = '{8'h41, 8'h1e, ctl[i][7] ? 8'hac : 8'hb5};
            cmpq("rx fifo", want, fifoGot);
        end
        chk("rssiValue", 16'h001e, 16'(rssiValue));
        wr(8'h0c, 8'h50);
        rssi(8'h20);
        rssi(8'h08);
        chk("peak rssi", 16'h0020, 16'(rssiValue));
        $display("receive done");
        wr(8'h0c, 8'h40);
        txGo();
        @(negedge ref_clk);
        cmpq("tx bytes", pay, fcm_mod_model_inst.got);
        chk("txFifoRead", 16'h1, 16'(pops));
        txFifoEmpty = 1'b1;
        txGo();
        chk("txUnderflow", 16'h1, 16'(txUnderflow));
        txFifoEmpty = 1'b0;
        wr(8'h0c, 8'h00);
        txGo();
        want = '{8'h41, 8'h41, 8'h41};
        cmpq("tx raw", want, fcm_mod_model_inst.got);
        $display("transmit done");
        wr(8'h0c, 8'h20);
        rxInfo.ackRequest = 1'b1;
        rxInfo.addrAccepted = 1'b1;
        rxInfo.seqNum = 8'h07;
        fcm_mod_model_inst.got.delete();
        rxf(pay);
        waitTx();
        @(negedge ref_clk);
        want = '{8'h02, 8'h00, 8'h07};
        crcq(want);
        cmpq("ack bytes", want, fcm_mod_model_inst.got);
        $display("auto ack done");
        results();
    end
endmodule // tb_top

// File: rtl/fcm_defs.svh
// Constants of the frame control and source match enable register bank.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FCM_DEFS_SVH
`define FCM_DEFS_SVH

// ----
// Register offsets
// ----
`define FCM_ADDR_SHORT_EN0 8'h04
`define FCM_ADDR_SHORT_EN1 8'h05
`define FCM_ADDR_SHORT_EN2 8'h06
`define FCM_ADDR_EXT_EN0 8'h08
`define FCM_ADDR_EXT_EN1 8'h09
`define FCM_ADDR_EXT_EN2 8'h0a
`define FCM_ADDR_FRM_CTRL 8'h0c

// ----
// Reset values and frame constants
// ----
`define FCM_RST_ENABLE 8'h00
`define FCM_RST_FRM_CTRL 8'h40
`define FCM_CRC_POLY 16'h8408
`define FCM_CRC_INIT 16'h0000
`define FCM_PRNG_SEED 16'hffff
`define FCM_FCS_BYTES 7'h02
`define FCM_ACK_FCF_LO 8'h02
`define FCM_ACK_FCF_HI 8'h00
`define FCM_ACK_LAST_IDX 2'h2

// ----
// Timing: clock period and acknowledgement turnaround
// ----
`define FCM_CLK_PERIOD_NS 20
`define FCM_SYMBOL_NS 16000
`define FCM_ACK_SYMBOLS 12
`define FCM_ACK_DELAY_CYCLES ((`FCM_ACK_SYMBOLS * `FCM_SYMBOL_NS) / `FCM_CLK_PERIOD_NS)

`endif

// File: rtl/fcm_frame_ctrl.sv
// Frame handling control, source match enables, checksum, status append,
// auto acknowledgement, signal strength capture and test modes.
// Assumes the serial bus decoder, FIFOs, modem and filter share ref_clk.
//
// Contract
// [R1] Short-address enable word: 24 bits, three bytes.
// [R2] Extended enable word held in three bytes.
// [R3] Extended entry written only from even bits.
// [R4] Extended entry read back on both bits.
// [R5] Host disables entry before rewriting it.
// [R6] Append select 0: strength, ok, correlation.
// [R7] Append select 1: strength, ok, match index.
// [R8] Transmit appends hardware CRC-16 when enabled.
// [R9] Host loads final bytes without hardware CRC.
// [R10] Receive checks CRC, stores status word.
// [R11] Checksum off: last two bytes unchanged.
// [R12] Acknowledgements unaffected by checksum setting.
// [R13] Auto-acknowledge twelve symbols after good frame.
// [R14] Strength register: latest or held peak.
// [R15] Receive modes: normal, loop, no symbol search.
// [R16] Transmit modes: normal, loop, pseudo-random.
// [R17] Frame control at 0x00C, resets 0x40.
// [R18] Normal transmit aborts on underflow.
// [R19] Host never programs reserved mode 01.
`timescale 1ns/100ps
`include "fcm_defs.svh"

module fcm_frame_ctrl
    import fcm_pkg::*;
#(
    parameter int ACK_DELAY_CYCLES = `FCM_ACK_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port from the serial bus decoder
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Enables towards the source match engine
    output logic [23:0] shortMatchEn,
    output logic [11:0] long_entry_match_enables,
    // Receive byte stream from the demodulator
    input wire logic rxByteValid,
    input wire logic [7:0] rxByte,
    input wire logic rxByteLast,
    input wire fcm_rx_info_t rxInfo,
    // Receive FIFO write side
    input wire logic rxFifoFull,
    output logic rxFifoWrite,
    output logic [7:0] rxFifoData,
    output logic rxOverflow,
    output logic symbolSearchEn,
    // Signal strength
    input wire logic rssiValid,
    input wire logic signed [7:0] rssiIn,
    output logic signed [7:0] rssiValue,
    // Transmit FIFO read side
    input wire logic txFifoEmpty,
    input wire logic [7:0] transmit_buffer_port,
    output logic txFifoRead,
    // Transmit control and byte stream to the modulator
    input wire logic txStart,
    input wire logic txStop,
    input wire logic [6:0] txLen,
    input wire logic txByteReq,
    output logic txByteValid,
    output logic [7:0] txByte,
    output logic txActive,
    output logic txDone,
    output logic txUnderflow,
    output logic ackSent
);

    // ----
    // Declarations
    // ----
    fcm_frm_ctrl_t frmCtrl;
    logic [3:0] extW [3];
    logic signed [7:0] rssiLatest;
    logic peakHoldDly;
    logic [7:0] rxHold0;
    logic [7:0] rxHold1;
    logic [1:0] rxHeld;
    logic [1:0] rxTail;
    logic [15:0] rxCrc;
    logic [15:0] next_rxCrc;
    logic rxCrcOk;
    fcm_rx_info_t rxInfoLat;
    logic emitValid;
    logic [7:0] emitByte;
    logic ackPending;
    logic [13:0] ackTimer;
    logic [7:0] ackSeq;
    fcm_tx_state_t txState;
    logic [6:0] txRemain;
    logic [1:0] ackIdx;
    logic [15:0] txCrc;

    // Extended enables: one stored bit per entry, two bits per entry on read.
    function automatic logic [7:0] ext_read(input logic [3:0] e);
        return {e[3], e[3], e[2], e[2], e[1], e[1], e[0], e[0]};
    endfunction
    function automatic logic [3:0] ext_write(input logic [7:0] w);
        return {w[6], w[4], w[2], w[0]};
    endfunction
    // Acknowledgement frame byte by position; feeds both the byte and its checksum.
    function automatic logic [7:0] ack_byte(input logic [1:0] i, input logic [7:0] s);
        case (i)
            2'h0: return `FCM_ACK_FCF_LO;
            2'h1: return `FCM_ACK_FCF_HI;
            default: return s;
        endcase
    endfunction

    // ----
    // Register writes
    // ----
    // Enable words; odd extended bits are dropped on write.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shortMatchEn <= {3{`FCM_RST_ENABLE}};
            extW[0] <= 4'(`FCM_RST_ENABLE);
            extW[1] <= 4'(`FCM_RST_ENABLE);
            extW[2] <= 4'(`FCM_RST_ENABLE);
        end else if (regWrite) begin
            case (regAddr)
                `FCM_ADDR_SHORT_EN0: shortMatchEn[7:0] <= regWrData;
                `FCM_ADDR_SHORT_EN1: shortMatchEn[15:8] <= regWrData;
                `FCM_ADDR_SHORT_EN2: shortMatchEn[23:16] <= regWrData; // [R1]
                `FCM_ADDR_EXT_EN0: extW[0] <= ext_write(regWrData); // [R3]
                `FCM_ADDR_EXT_EN1: extW[1] <= ext_write(regWrData); // [R2]
                `FCM_ADDR_EXT_EN2: extW[2] <= ext_write(regWrData); // [R2]
                default: ;
            endcase
        end
    end

    // Frame handling control register.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frmCtrl <= `FCM_RST_FRM_CTRL; // [R17]
        end else if (regWrite && regAddr == `FCM_ADDR_FRM_CTRL) begin
            frmCtrl <= regWrData; // [R17]
        end
    end

    // Enables presented to the match engine.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            long_entry_match_enables <= '0;
        end else begin
            long_entry_match_enables <= {extW[2], extW[1], extW[0]};
        end
    end

    // ----
    // Register reads
    // ----
    // Read data is registered one cycle after the read strobe; unmapped is zero.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            regRdData <= '0;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                case (regAddr)
                    `FCM_ADDR_SHORT_EN0: regRdData <= shortMatchEn[7:0];
                    `FCM_ADDR_SHORT_EN1: regRdData <= shortMatchEn[15:8];
                    `FCM_ADDR_SHORT_EN2: regRdData <= shortMatchEn[23:16];
                    `FCM_ADDR_EXT_EN0: regRdData <= ext_read(extW[0]); // [R4]
                    `FCM_ADDR_EXT_EN1: regRdData <= ext_read(extW[1]); // [R4]
                    `FCM_ADDR_EXT_EN2: regRdData <= ext_read(extW[2]); // [R4]
                    `FCM_ADDR_FRM_CTRL: regRdData <= frmCtrl;
                    default: regRdData <= '0;
                endcase
            end
        end
    end

    // ----
    // Signal strength capture
    // ----
    // Latest sample always tracked; the report holds the peak in peak mode.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rssiLatest <= '0;
            rssiValue <= '0;
            peakHoldDly <= 1'b0;
        end else begin
            peakHoldDly <= frmCtrl.peakHold;
            if (rssiValid) begin
                rssiLatest <= rssiIn;
            end
            if (!frmCtrl.peakHold || !peakHoldDly) begin
                rssiValue <= rssiValid ? rssiIn : rssiLatest; // [R14]
            end else if (rssiValid && rssiIn > rssiValue) begin
                rssiValue <= rssiIn; // [R14]
            end
        end
    end

    // ----
    // Receive path
    // ----
    // Checksum over every byte, the check field included, leaves zero.
    assign next_rxCrc = fcm_crc_byte(rxCrc, rxByte);

    // Two bytes are held back so the check field can be replaced at the end.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rxHold0 <= '0;
            rxHold1 <= '0;
            rxHeld <= '0;
            rxTail <= '0;
            rxCrc <= `FCM_CRC_INIT;
            rxCrcOk <= 1'b0;
            rxInfoLat <= '0;
        end else if (rxByteValid) begin
            rxHold0 <= rxHold1;
            rxHold1 <= rxByte;
            rxHeld <= (rxHeld == 2'h2 || rxByteLast) ? 2'h2 : rxHeld + 2'h1;
            rxCrc <= rxByteLast ? `FCM_CRC_INIT : next_rxCrc;
            if (rxByteLast) begin
                rxTail <= 2'h2;
                rxHeld <= '0;
                rxCrcOk <= (next_rxCrc == 16'h0000); // [R10]
                rxInfoLat <= rxInfo;
            end
        end else if (rxTail != 2'h0) begin
            rxTail <= rxTail - 2'h1;
            rxHold0 <= rxHold1;
        end
    end

    // Byte chosen for the FIFO this cycle.
    always_comb begin
        emitValid = 1'b0;
        emitByte = rxHold0;
        if (rxByteValid && rxHeld == 2'h2) begin
            emitValid = 1'b1;
        end else if (!rxByteValid && rxTail == 2'h2) begin
            emitValid = 1'b1;
            if (frmCtrl.hw_checksum_enable) begin
                emitByte = rssiLatest; // [R6]
            end
        end else if (!rxByteValid && rxTail == 2'h1) begin
            emitValid = 1'b1;
            if (!frmCtrl.hw_checksum_enable) begin
                emitByte = rxHold0; // [R11]
            end else if (frmCtrl.status_append_select) begin
                emitByte = {rxCrcOk, rxInfoLat.source_match_result_index}; // [R7]
            end else begin
                emitByte = {rxCrcOk, rxInfoLat.correlation}; // [R6]
            end
        end
    end

    // FIFO write; looping mode writes through a full FIFO without complaint.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rxFifoWrite <= 1'b0;
            rxFifoData <= '0;
            rxOverflow <= 1'b0;
            symbolSearchEn <= 1'b1;
        end else begin
            symbolSearchEn <= (frmCtrl.rxMode != FCM_RX_NO_SYNC); // [R15]
            rxFifoData <= emitByte;
            if (frmCtrl.rxMode == FCM_RX_LOOP) begin
                rxFifoWrite <= emitValid; // [R15]
                rxOverflow <= 1'b0;
            end else begin
                rxFifoWrite <= emitValid && !rxFifoFull;
                rxOverflow <= emitValid && rxFifoFull;
            end
        end
    end

    // ----
    // Automatic acknowledgement timing
    // ----
    // A good, accepted frame asking for it starts the turnaround count.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ackPending <= 1'b0;
            ackTimer <= '0;
            ackSeq <= '0;
        end else if (rxByteValid && rxByteLast && frmCtrl.autoAck && rxInfo.ackRequest
                     && rxInfo.addrAccepted && next_rxCrc == 16'h0000) begin
            ackPending <= 1'b1; // [R13]
            ackTimer <= 14'(ACK_DELAY_CYCLES - 1);
            ackSeq <= rxInfo.seqNum;
        end else if (ackPending && ackTimer != 14'h0000) begin
            ackTimer <= ackTimer - 14'h0001; // [R13]
        end else if (ackPending && txState == FCM_TX_IDLE) begin
            ackPending <= 1'b0;
        end
    end

    // ----
    // Transmit sequencer
    // ----
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            txState <= FCM_TX_IDLE;
            txRemain <= '0;
            ackIdx <= '0;
            txCrc <= `FCM_CRC_INIT;
            txByteValid <= 1'b0;
            txByte <= '0;
            txFifoRead <= 1'b0;
            txDone <= 1'b0;
            txUnderflow <= 1'b0;
            ackSent <= 1'b0;
        end else begin
            txByteValid <= 1'b0;
            txFifoRead <= 1'b0;
            txDone <= 1'b0;
            txUnderflow <= 1'b0;
            ackSent <= 1'b0;
            case (txState)
                FCM_TX_IDLE: begin
                    txCrc <= `FCM_CRC_INIT;
                    ackIdx <= '0;
                    if (ackPending && ackTimer == 14'h0000) begin
                        txState <= FCM_TX_ACK; // [R13]
                    end else if (txStart && frmCtrl.txMode == FCM_TX_PRNG) begin
                        txCrc <= `FCM_PRNG_SEED;
                        txState <= FCM_TX_RANDOM; // [R16]
                    end else if (txStart) begin
                        txRemain <= frmCtrl.hw_checksum_enable ? txLen - `FCM_FCS_BYTES
                                                               : txLen; // [R8]
                        txState <= FCM_TX_DATA;
                    end
                end
                FCM_TX_DATA: begin
                    if (txStop) begin
                        txState <= FCM_TX_IDLE;
                    end else if (txRemain == 7'h00 && frmCtrl.txMode != FCM_TX_LOOP) begin
                        if (frmCtrl.hw_checksum_enable) begin
                            txState <= FCM_TX_CRC_LO; // [R8]
                        end else begin
                            txDone <= 1'b1; // [R9]
                            txState <= FCM_TX_IDLE;
                        end
                    end else if (txByteReq) begin
                        if (txFifoEmpty && frmCtrl.txMode != FCM_TX_LOOP) begin
                            txUnderflow <= 1'b1; // [R18]
                            txState <= FCM_TX_IDLE; // [R18]
                        end else begin
                            txByteValid <= 1'b1; // [R16]
                            txByte <= transmit_buffer_port;
                            txFifoRead <= !txFifoEmpty;
                            txCrc <= fcm_crc_byte(txCrc, transmit_buffer_port);
                            if (frmCtrl.txMode != FCM_TX_LOOP) begin
                                txRemain <= txRemain - 7'h01;
                            end
                        end
                    end
                end
                FCM_TX_ACK: begin
                    // Acknowledgements always carry a hardware checksum.
                    if (txByteReq) begin
                        txByteValid <= 1'b1;
                        ackIdx <= ackIdx + 2'h1;
                        txByte <= ack_byte(ackIdx, ackSeq);
                        txCrc <= fcm_crc_byte(txCrc, ack_byte(ackIdx, ackSeq));
                        if (ackIdx == `FCM_ACK_LAST_IDX) begin
                            txState <= FCM_TX_CRC_LO; // [R12]
                        end
                    end
                end
                FCM_TX_CRC_LO: begin
                    if (txByteReq) begin
                        txByteValid <= 1'b1;
                        txByte <= txCrc[7:0]; // [R8]
                        txState <= FCM_TX_CRC_HI;
                    end
                end
                FCM_TX_CRC_HI: begin
                    if (txByteReq) begin
                        txByteValid <= 1'b1;
                        txByte <= txCrc[15:8]; // [R8]
                        txDone <= 1'b1;
                        ackSent <= (ackIdx == 2'h3); // [R13]
                        txState <= FCM_TX_IDLE;
                    end
                end
                FCM_TX_RANDOM: begin
                    if (txStop) begin
                        txState <= FCM_TX_IDLE;
                    end else if (txByteReq) begin
                        txByteValid <= 1'b1;
                        txByte <= txCrc[7:0]; // [R16]
                        txCrc <= fcm_crc_byte(txCrc, txCrc[15:8]);
                    end
                end
                default: txState <= FCM_TX_IDLE;
            endcase
        end
    end

    // Busy flag for the radio controller.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            txActive <= 1'b0;
        end else begin
            txActive <= (txState != FCM_TX_IDLE);
        end
    end

endmodule // fcm_frame_ctrl

// File: rtl/fcm_pkg.sv
// Types and shared functions of the frame control register bank.
// Assumes fcm_defs.svh is on the include path.
`include "fcm_defs.svh"

package fcm_pkg;

    // ----
    // Frame handling control layout, bit 7 down to bit 0
    // ----
    typedef struct packed {
        logic status_append_select;
        logic hw_checksum_enable;
        logic autoAck;
        logic peakHold;
        logic [1:0] rxMode;
        logic [1:0] txMode;
    } fcm_frm_ctrl_t;

    // Receive and transmit mode encodings.
    typedef enum logic [1:0] {
        FCM_RX_NORMAL = 2'h0, FCM_RX_RSVD = 2'h1, FCM_RX_LOOP = 2'h2, FCM_RX_NO_SYNC = 2'h3
    } fcm_rx_mode_t;
    typedef enum logic [1:0] {
        FCM_TX_NORMAL = 2'h0, FCM_TX_RSVD = 2'h1, FCM_TX_LOOP = 2'h2, FCM_TX_PRNG = 2'h3
    } fcm_tx_mode_t;

    // Received frame facts that arrive with the last byte.
    typedef struct packed {
        logic ackRequest;
        logic addrAccepted;
        logic [7:0] seqNum;
        logic [6:0] correlation;
        logic [6:0] source_match_result_index;
    } fcm_rx_info_t;

    // Transmit sequencer states.
    typedef enum logic [5:0] {
        FCM_TX_IDLE = 6'b000001,
        FCM_TX_DATA = 6'b000010,
        FCM_TX_ACK = 6'b000100,
        FCM_TX_CRC_LO = 6'b001000,
        FCM_TX_CRC_HI = 6'b010000,
        FCM_TX_RANDOM = 6'b100000
    } fcm_tx_state_t;

    // One byte of the ITU-T CRC-16, least significant bit first.
    function automatic logic [15:0] fcm_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `FCM_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

endpackage
